// >>> logic/bss_cfg.svh
// constants for the boot source select block
`ifndef BSS_CFG_SVH
`define BSS_CFG_SVH
`define BSS_MODE_LPC 1'h0
`define BSS_MODE_ESPI 1'h1
`define BSS_CS_IDLE 1'h1
`define BSS_FLAG_CLEAR 1'h0
`define BSS_STRAP_RESET 3'h7
`endif

// >>> logic/bss_pkg.sv
// types for the boot source select block
package bss_pkg;
    typedef enum logic [1:0] {
        BSS_CFG_MOD_ON_ONE,
        BSS_CFG_MOD_ON_ZERO,
        BSS_CFG_MOD_ONLY
    } bss_route_type;
    typedef enum logic {
        BSS_SAMPLE,
        BSS_HOLD
    } bss_phase_type;
endpackage

// >>> logic/bss_pin_mux.sv
// one shared host-link pin steered between lpc and espi functions
`timescale 1ns/1ps
module bss_pin_mux (
    input wire logic espi_mode,
    input wire logic lpc_out,
    input wire logic lpc_oe,
    input wire logic espi_out,
    input wire logic espi_oe,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic lpc_in,
    output logic espi_in
);
    assign pin_out = espi_mode ? espi_out : lpc_out;
    assign pin_oe = espi_mode ? espi_oe : lpc_oe;
    assign lpc_in = espi_mode ? 1'h1 : pin_in;
    assign espi_in = espi_mode ? pin_in : 1'h1;
endmodule

// >>> logic/bss_boot_select.sv
// boot source select and host-link mode logic
`timescale 1ns/1ps
`include "bss_cfg.svh"
module bss_boot_select #(
    parameter int PINS = 10
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic host_link_mode_strap_n,
    input wire logic boot_disable_strap_hi_n,
    input wire logic boot_disable_strap_lo_n,
    input wire logic module_espi_config,
    input wire logic flash_select_one_n,
    input wire logic flash_select_zero_n,
    output logic module_flash_cs_n,
    output logic carrier_flash_cs_n,
    output logic carrier_descriptor,
    output logic espi_mode,
    output logic boot_enable,
    output logic mode_mismatch,
    output bss_pkg::bss_route_type route,
    output bss_pkg::bss_phase_type phase,
    input wire logic [PINS-1:0] lpc_out,
    input wire logic [PINS-1:0] lpc_oe,
    input wire logic [PINS-1:0] espi_out,
    input wire logic [PINS-1:0] espi_oe,
    input wire logic [PINS-1:0] link_pin_in,
    output logic [PINS-1:0] link_pin_out,
    output logic [PINS-1:0] link_pin_oe,
    output logic [PINS-1:0] lpc_in,
    output logic [PINS-1:0] espi_in
);
    import bss_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // strap capture
    logic [2:0] strap_reg;
    logic [2:0] strap_next;
    bss_phase_type phase_reg;
    bss_phase_type phase_next;
    logic mismatch_reg;
    logic mismatch_next;
    bss_route_type route_reg;
    bss_route_type route_next;
    logic espi_reg;
    logic espi_next;
    logic descriptor_reg;
    logic descriptor_next;

    always_comb begin
        strap_next = strap_reg;
        phase_next = phase_reg;
        if (reset) begin
            // capture straps on every edge that sees reset held
            strap_next = {host_link_mode_strap_n, boot_disable_strap_hi_n,
                boot_disable_strap_lo_n};
        end
        case (phase_reg)
            BSS_SAMPLE: begin
                // last capture in reset is kept from here on
                if (!reset) begin
                    phase_next = BSS_HOLD;
                end
            end
            BSS_HOLD: begin
                if (reset) begin
                    phase_next = BSS_SAMPLE;
                end
            end
            default: begin
                phase_next = BSS_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            phase_reg <= BSS_SAMPLE;
        end else begin
            phase_reg <= phase_next;
        end
        strap_reg <= strap_next;
    end

    always_comb begin
        // open host-mode strap pulled high gives lpc
        espi_next = (strap_reg[2] == 1'b0) ? `BSS_MODE_ESPI : `BSS_MODE_LPC;
        if (strap_reg[2] && strap_reg[1]) begin
            route_next = BSS_CFG_MOD_ONLY;
        end else if (strap_reg[1]) begin
            // no controller-attached boot, fall back to 000
            route_next = BSS_CFG_MOD_ON_ZERO;
        end else if (strap_reg[0]) begin
            route_next = BSS_CFG_MOD_ON_ONE;
        end else begin
            route_next = BSS_CFG_MOD_ON_ZERO;
        end
        // withhold boot when the strap disagrees with the module build
        mismatch_next = (espi_next != module_espi_config);
        // carrier descriptor only when the carrier holds the boot flash
        descriptor_next = (route_next == BSS_CFG_MOD_ON_ONE) && !mismatch_next;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            espi_reg <= `BSS_MODE_LPC;
            route_reg <= BSS_CFG_MOD_ONLY;
            mismatch_reg <= `BSS_FLAG_CLEAR;
            descriptor_reg <= `BSS_FLAG_CLEAR;
        end else begin
            espi_reg <= espi_next;
            route_reg <= route_next;
            mismatch_reg <= mismatch_next;
            descriptor_reg <= descriptor_next;
        end
    end

    assign phase = phase_reg;
    assign route = route_reg;
    assign espi_mode = espi_reg;
    assign mode_mismatch = mismatch_reg;
    assign carrier_descriptor = descriptor_reg;
    // withhold boot on mismatch and during reset
    assign boot_enable = !reset && (phase_reg == BSS_HOLD) && !mismatch_reg;
    ////////////////////////////////////////////////////////////////////////////
    // chip select steering
    always_comb begin
        module_flash_cs_n = `BSS_CS_IDLE;
        carrier_flash_cs_n = `BSS_CS_IDLE;
        if (boot_enable) begin
            case (route_reg)
                BSS_CFG_MOD_ON_ZERO: begin
                    module_flash_cs_n = flash_select_zero_n;
                    carrier_flash_cs_n = flash_select_one_n;
                end
                BSS_CFG_MOD_ON_ONE: begin
                    module_flash_cs_n = flash_select_one_n;
                    carrier_flash_cs_n = flash_select_zero_n;
                end
                BSS_CFG_MOD_ONLY: begin
                    module_flash_cs_n = flash_select_zero_n & flash_select_one_n;
                    carrier_flash_cs_n = `BSS_CS_IDLE;
                end
                default: begin
                    module_flash_cs_n = `BSS_CS_IDLE;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // shared host-link pins
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            bss_pin_mux i_bss_pin_mux (
                .espi_mode(espi_reg),
                .lpc_out(lpc_out[gi]),
                .lpc_oe(lpc_oe[gi] & boot_enable),
                .espi_out(espi_out[gi]),
                .espi_oe(espi_oe[gi] & boot_enable),
                .pin_in(link_pin_in[gi]),
                .pin_out(link_pin_out[gi]),
                .pin_oe(link_pin_oe[gi]),
                .lpc_in(lpc_in[gi]),
                .espi_in(espi_in[gi])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_carrier_idle: assert property (@(posedge sys_clk) disable iff (reset)
        route_reg == BSS_CFG_MOD_ONLY |-> carrier_flash_cs_n)
        else $error("carrier select active in module-only routing");
    a_strap_hold: assert property (@(posedge sys_clk) disable iff (reset)
        phase_reg == BSS_HOLD && $past(phase_reg) == BSS_HOLD |-> $stable(strap_reg))
        else $error("straps changed after reset");
    a_espi_decode: assert property (@(posedge sys_clk) disable iff (reset)
        phase_reg == BSS_HOLD |-> espi_reg == !strap_reg[2])
        else $error("host link mode does not follow strap");
    a_mismatch_block: assert property (@(posedge sys_clk) disable iff (reset)
        mismatch_reg |-> !boot_enable && module_flash_cs_n && carrier_flash_cs_n)
        else $error("boot proceeds on mode mismatch");
    a_espi_fallback: assert property (@(posedge sys_clk) disable iff (reset)
        phase_reg == BSS_HOLD && strap_reg[2:1] == 2'h1 |=> route_reg == BSS_CFG_MOD_ON_ZERO)
        else $error("espi with upper disable not treated as 000");
    a_carrier_one: assert property (@(posedge sys_clk) disable iff (reset)
        boot_enable && route_reg == BSS_CFG_MOD_ON_ZERO
        |-> carrier_flash_cs_n == flash_select_one_n && !carrier_descriptor)
        else $error("carrier select not from select one");
    a_carrier_zero: assert property (@(posedge sys_clk) disable iff (reset)
        boot_enable && route_reg == BSS_CFG_MOD_ON_ONE
        |-> carrier_flash_cs_n == flash_select_zero_n && carrier_descriptor)
        else $error("carrier select not from select zero");
    a_pin_mode: assert property (@(posedge sys_clk) disable iff (reset)
        boot_enable && espi_reg |-> link_pin_out == espi_out)
        else $error("shared pins not carrying espi");
    a_module_zero: assert property (@(posedge sys_clk) disable iff (reset)
        boot_enable && route_reg == BSS_CFG_MOD_ON_ZERO
        |-> module_flash_cs_n == flash_select_zero_n)
        else $error("module select not from select zero");
    a_module_one: assert property (@(posedge sys_clk) disable iff (reset)
        boot_enable && route_reg == BSS_CFG_MOD_ON_ONE
        |-> module_flash_cs_n == flash_select_one_n)
        else $error("module select not from select one");
    a_module_only: assert property (@(posedge sys_clk) disable iff (reset)
        boot_enable && route_reg == BSS_CFG_MOD_ONLY
        |-> module_flash_cs_n == (flash_select_zero_n & flash_select_one_n))
        else $error("module-only select not from either select");
    a_upper_route: assert property (@(posedge sys_clk) disable iff (reset)
        phase_reg == BSS_HOLD && strap_reg[2:1] == 2'h3 |-> route_reg == BSS_CFG_MOD_ONLY)
        else $error("upper disable not routed to module only");
    a_lower_route: assert property (@(posedge sys_clk) disable iff (reset)
        phase_reg == BSS_HOLD && strap_reg[1:0] == 2'h1 |-> route_reg == BSS_CFG_MOD_ON_ONE)
        else $error("lower disable not routed to carrier flash");
    a_withhold_pins: assert property (@(posedge sys_clk) disable iff (reset)
        mismatch_reg |-> link_pin_oe == '0 && !carrier_descriptor)
        else $error("pins or descriptor driven on mode mismatch");
    a_lpc_pins: assert property (@(posedge sys_clk) disable iff (reset)
        boot_enable && !espi_reg |-> link_pin_out == lpc_out)
        else $error("shared pins not carrying lpc");
    a_idle_inputs: assert property (@(posedge sys_clk) disable iff (reset)
        espi_reg |-> lpc_in == '1 && espi_in == link_pin_in)
        else $error("pin inputs not steered to espi side");
    a_boot_release: assert property (@(posedge sys_clk) disable iff (reset)
        phase_reg == BSS_HOLD && !mismatch_reg |-> boot_enable)
        else $error("boot not enabled after reset release");
endmodule

// >>> bench/bss_carrier_model.sv
// carrier board strap wiring and carrier boot flash model
`timescale 1ns/1ps
module bss_carrier_model (
    input wire logic strap_open,
    input wire logic espi_request,
    input wire logic disable_hi_n,
    input wire logic disable_lo_n,
    input wire logic carrier_flash_cs_n,
    output logic host_link_mode_strap_n,
    output logic boot_disable_strap_hi_n,
    output logic boot_disable_strap_lo_n,
    output logic carrier_flash_busy
);
    // open strap reads high through the pull-up, espi ties it to ground
    assign host_link_mode_strap_n = strap_open ? 1'b1 : ~espi_request;
    assign boot_disable_strap_hi_n = disable_hi_n;
    assign boot_disable_strap_lo_n = disable_lo_n;
    assign carrier_flash_busy = ~carrier_flash_cs_n;
endmodule

// >>> bench/tb_bss_boot_select.sv
// testbench for the boot source select block
`timescale 1ns/1ps
module tb_bss_boot_select;
    import bss_pkg::*;
    logic sys_clk, reset, cfg, s1, s0, open_s, esp_req, hi, lo, hm_n, hi_n, lo_n;
    logic mcs, ccs, desc, espi, ben, mism;
    bss_route_type route;
    bss_phase_type phase;
    logic [9:0] lo_out, es_out, oe, pin_in, pin_out, pin_oe, lpc_in, espi_in;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    bss_carrier_model i_bss_carrier_model (.strap_open(open_s), .espi_request(esp_req),
        .disable_hi_n(hi), .disable_lo_n(lo), .carrier_flash_cs_n(ccs),
        .host_link_mode_strap_n(hm_n), .boot_disable_strap_hi_n(hi_n),
        .boot_disable_strap_lo_n(lo_n), .carrier_flash_busy());
    bss_boot_select i_bss_boot_select (.sys_clk(sys_clk), .reset(reset),
        .host_link_mode_strap_n(hm_n), .boot_disable_strap_hi_n(hi_n),
        .boot_disable_strap_lo_n(lo_n), .module_espi_config(cfg), .flash_select_one_n(s1),
        .flash_select_zero_n(s0), .module_flash_cs_n(mcs), .carrier_flash_cs_n(ccs),
        .carrier_descriptor(desc), .espi_mode(espi), .boot_enable(ben), .mode_mismatch(mism),
        .route(route), .phase(phase), .lpc_out(lo_out), .lpc_oe(oe), .espi_out(es_out),
        .espi_oe(oe), .link_pin_in(pin_in), .link_pin_out(pin_out), .link_pin_oe(pin_oe),
        .lpc_in(lpc_in), .espi_in(espi_in));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic check(string name, logic [9:0] got, logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // straps applied during reset, then released
    task automatic strap_reset(logic op, logic hm, logic h, logic l, logic c);
        @(posedge sys_clk);
        reset <= 1'b1;
        open_s <= op;
        esp_req <= ~hm;
        hi <= h;
        lo <= l;
        cfg <= c;
        pin_in <= {hm, h, l, 7'h55};
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic run_config(logic hm, logic h, logic l);
        logic c_one, c_zero, a, b;
        bss_route_type r_exp;
        c_one = (~h & ~l) | (~hm & h);
        c_zero = ~h & l;
        r_exp = c_one ? BSS_CFG_MOD_ON_ZERO : c_zero ? BSS_CFG_MOD_ON_ONE :
            BSS_CFG_MOD_ONLY;
        strap_reset(1'h0, hm, h, l, ~hm);
        check("espi_mode", espi, !hm);
        check("boot_enable", ben, 1'h1);
        check("mismatch_clear", mism, 1'h0);
        check("phase", phase, BSS_HOLD);
        check("route", route, r_exp);
        check("descriptor", desc, c_zero);
        check("pin_out", pin_out, hm ? lo_out : es_out);
        check("pin_oe", pin_oe, oe);
        check("espi_in", espi_in, hm ? 10'h3FF : pin_in);
        check("lpc_in", lpc_in, hm ? pin_in : 10'h3FF);
        for (int k = 0; k < 4; k++) begin
            a = k[0];
            b = k[1];
            @(posedge sys_clk);
            s1 <= a;
            s0 <= b;
            esp_req <= hm;
            hi <= ~h;
            #1;
            check("carrier_cs", ccs, c_one ? a : c_zero ? b : 1'b1);
            check("module_cs", mcs, c_one ? b : c_zero ? a : a & b);
        end
        @(posedge sys_clk);
        #1;
        check("held_mode", espi, !hm);
        check("held_route", route, r_exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {cfg, s1, s0, open_s, esp_req, hi, lo} = 7'h00;
        lo_out = 10'h155;
        es_out = 10'h2AA;
        oe = 10'h3FF;
        pin_in = 10'h000;
        for (int n = 0; n < 8; n++) run_config(n[2], n[1], n[0]);
        strap_reset(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        check("open_strap_mode", espi, 1'b0);
        @(posedge sys_clk);
        s1 <= 1'b0;
        s0 <= 1'b0;
        strap_reset(1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
        check("mismatch", mism, 1'h1);
        check("withheld", ben, 1'h0);
        check("cs_idle", {mcs, ccs}, 2'h3);
        check("oe_off", pin_oe, 10'h000);
        check("desc_off", desc, 1'h0);
        strap_reset(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
        check("mismatch_espi", mism, 1'h1);
        check("withheld_espi", ben, 1'h0);
        check("cs_idle_espi", {mcs, ccs}, 2'h3);
        tally_and_finish();
    end
endmodule
